/* File: logic/vste_top.sv */
// Purpose: Sync, back-porch, field and format outputs from sliced video
// Assumes: Sliced sync inputs are asynchronous; sampled on I_VID_CLK
// Notes: Fine pulse widths are timed on I_REF_CLK after a toggle crossing
//
// What this block does
// - With no input, line sync, field sync and back-porch outputs rest high.
// - Composite sync output reproduces the input pulses below blanking.
// - Line sync is active low, falling after the input timing reference.
// - Line sync trailing edges are rebuilt; receivers use falling edges only.
// - Field sync falls at first serration, stays low about three lines.
// - Back-porch gate pulses low after each sync pulse; width depends on format.
// - Standard definition gate starts on sync rise, covers the burst.
// - Standard definition gate shortens inside the vertical interval.
// - Enhanced definition gate always uses the shorter width.
// - High definition gate starts on tri-level trailing edge, narrowest width.
// - Interlaced parity is high in field one, low in field two.
// - Parity changes together with the field sync falling edge.
// - Progressive formats keep parity high.
// - Count line syncs per field, skipping those during field sync.
// - The per-field count goes out serially as an 11-bit word.
// - Word bits go out on 11 line syncs, starting at the third.
// - Outside the 11 bit periods the format output is don't-care.
// - Interlaced counts: 260/259, 310/309, 560/559 per field.
// - Progressive counts: 522, 622, 747, 1122, one per format.
// - Outputs become valid after a lock period of one or two fields.
// - Line sync low lasts 525 ns at 720 lines, 475 ns at 1080.
module vste_pulse #(
   parameter int W = 8
)
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_fire,
   input wire logic [W-1:0] i_width,
   output logic o_low_n
);
   logic [W-1:0] cnt;

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         cnt <= '0;
         o_low_n <= 1'b1;
      end
      else if (i_fire)
      begin
         cnt <= W'(i_width - 1'b1);
         o_low_n <= 1'b0;
      end
      else if (cnt != '0)
         cnt <= W'(cnt - 1'b1);
      else
         o_low_n <= 1'b1;
   end
endmodule

module vste_top
(
   input wire logic I_REF_CLK,
   input wire logic I_RST_N,
   input wire logic I_VID_CLK,
   input wire logic I_SYNC_BELOW_N,
   input wire logic I_SYNC_TRI_POS,
   output logic O_COMPOSITE_SYNC_OUT,
   output wire logic O_LINE_SYNC_OUT,
   output logic O_FIELD_SYNC_OUT,
   output wire logic O_BACK_PORCH_GATE_OUT,
   output logic O_FIELD_PARITY_OUT,
   output logic O_LINE_COUNT_SERIAL_OUT
);
   localparam int TW = vste_pkg::TMR_W;
   localparam int PW = vste_pkg::PW_W;

   // ==========================================================
   // Video domain: input sampling and edge detection
   logic [1:0] s_sync;
   logic [1:0] s_pos;
   logic prev_sync;
   logic prev_pos;
   logic sync_fall;
   logic sync_rise;
   logic pos_fall;

   always_ff @(posedge I_VID_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         s_sync <= 2'h3;
         s_pos <= 2'h0;
         prev_sync <= 1'b1;
         prev_pos <= 1'b0;
      end
      else
      begin
         s_sync <= {s_sync[0], I_SYNC_BELOW_N};
         s_pos <= {s_pos[0], I_SYNC_TRI_POS};
         prev_sync <= s_sync[1];
         prev_pos <= s_pos[1];
      end
   end

   assign sync_fall = prev_sync & ~s_sync[1];
   assign sync_rise = ~prev_sync & s_sync[1];
   assign pos_fall = prev_pos & ~s_pos[1];

   // ==========================================================
   // Video domain: line timing, lock and signal presence
   logic [TW-1:0] since_hs;
   logic [TW-1:0] low_cnt;
   logic [TW-1:0] idle_cnt;
   logic [TW-1:0] period;
   logic [4:0] misses;
   logic nosig;
   logic hs_accept;
   logic broad_end;
   logic fall_aligned;
   logic vert;
   logic vs_active;
   logic vs_start;
   logic [3:0] vcount;

   // Half-line equalizing edges fall short of the gate and are dropped
   assign hs_accept = sync_fall && !nosig &&
      (since_hs >= TW'(period - (period >> 2)));
   assign broad_end = sync_rise && (period != '0) &&
      (low_cnt > (period >> 3));
   assign vs_start = broad_end && !vert && !nosig;

   always_ff @(posedge I_VID_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         since_hs <= '0;
         low_cnt <= '0;
         idle_cnt <= '0;
         nosig <= 1'b1;
      end
      else
      begin
         since_hs <= hs_accept ? TW'(1) :
            ((since_hs == '1) ? since_hs : TW'(since_hs + 1'b1));
         low_cnt <= s_sync[1] ? '0 :
            ((low_cnt == '1) ? low_cnt : TW'(low_cnt + 1'b1));
         idle_cnt <= (sync_fall || sync_rise) ? '0 :
            ((idle_cnt == '1) ? idle_cnt : TW'(idle_cnt + 1'b1));
         nosig <= (idle_cnt >= vste_pkg::NOSIG_VCYC);
      end
   end

   // Period learns only from accepted edges; repeated misses force relock
   always_ff @(posedge I_VID_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         period <= '0;
         misses <= '0;
      end
      else if (nosig)
      begin
         period <= '0;
         misses <= '0;
      end
      else if (hs_accept)
      begin
         period <= since_hs;
         misses <= '0;
      end
      else if (sync_fall && !vert)
      begin
         if (misses == vste_pkg::RELOCK_MISSES)
         begin
            period <= '0;
            misses <= '0;
         end
         else
            misses <= 5'(misses + 1'b1);
      end
   end

   // ==========================================================
   // Video domain: field sync, vertical zone and parity
   always_ff @(posedge I_VID_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         vcount <= vste_pkg::VERT_LINES;
         vert <= 1'b0;
         vs_active <= 1'b0;
         fall_aligned <= 1'b1;
         O_FIELD_PARITY_OUT <= 1'b1;
      end
      else
      begin
         if (sync_fall)
            fall_aligned <= hs_accept;
         if (vs_start)
         begin
            vcount <= '0;
            vert <= 1'b1;
            vs_active <= 1'b1;
            // Broad pulse on a line start marks field one
            O_FIELD_PARITY_OUT <= fall_aligned;
         end
         else if (nosig)
         begin
            vert <= 1'b0;
            vs_active <= 1'b0;
         end
         else if (hs_accept && vert)
         begin
            vcount <= 4'(vcount + 1'b1);
            if (4'(vcount + 1'b1) == vste_pkg::VS_LINES)
               vs_active <= 1'b0;
            if (4'(vcount + 1'b1) == vste_pkg::VERT_LINES)
               vert <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Video domain: line count and serial format word
   logic [vste_pkg::FMT_BITS-1:0] line_cnt;
   logic [vste_pkg::FMT_BITS-1:0] fmt_word;
   logic [vste_pkg::FMT_BITS-1:0] shreg;
   logic [1:0] ser_cnt;
   logic [3:0] bits_left;
   logic fmt_bit;
   vste_pkg::vste_ser_t ser_state;

   always_ff @(posedge I_VID_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         line_cnt <= '0;
         fmt_word <= '0;
      end
      else if (vs_start)
      begin
         fmt_word <= line_cnt;
         line_cnt <= '0;
      end
      else if (hs_accept && !vs_active)
         line_cnt <= 11'(line_cnt + 1'b1);
   end

   always_ff @(posedge I_VID_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         ser_state <= vste_pkg::VSTE_SER_IDLE;
         ser_cnt <= '0;
         bits_left <= '0;
         shreg <= '0;
         fmt_bit <= 1'b0;
      end
      else if (vs_start)
      begin
         ser_state <= vste_pkg::VSTE_SER_WAIT;
         ser_cnt <= '0;
      end
      else
      begin
         case (ser_state)
            vste_pkg::VSTE_SER_IDLE:
               ser_cnt <= '0;
            vste_pkg::VSTE_SER_WAIT:
               if (hs_accept)
               begin
                  ser_cnt <= 2'(ser_cnt + 1'b1);
                  if (2'(ser_cnt + 1'b1) == vste_pkg::FMT_FIRST_HS)
                  begin
                     fmt_bit <= fmt_word[vste_pkg::FMT_BITS-1];
                     shreg <= {fmt_word[vste_pkg::FMT_BITS-2:0], 1'b0};
                     bits_left <= 4'(vste_pkg::FMT_BITS_CNT - 1'b1);
                     ser_state <= vste_pkg::VSTE_SER_SHIFT;
                  end
               end
            vste_pkg::VSTE_SER_SHIFT:
               if (hs_accept)
               begin
                  // Highest bit first, one bit per line
                  fmt_bit <= shreg[vste_pkg::FMT_BITS-1];
                  shreg <= {shreg[vste_pkg::FMT_BITS-2:0], 1'b0};
                  bits_left <= 4'(bits_left - 1'b1);
                  if (bits_left == 4'h1)
                     ser_state <= vste_pkg::VSTE_SER_IDLE;
               end
            default:
               ser_state <= vste_pkg::VSTE_SER_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Video domain: class detection and events toward the timer side
   logic pos_seen;
   logic hd;
   vste_pkg::vste_class_t cls;
   vste_pkg::vste_evt_t evt;
   vste_pkg::vste_xing_t vx;
   logic bp_trig;

   always_ff @(posedge I_VID_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         pos_seen <= 1'b0;
         hd <= 1'b0;
      end
      else if (nosig)
      begin
         pos_seen <= 1'b0;
         hd <= 1'b0;
      end
      else if (hs_accept)
      begin
         hd <= pos_seen | pos_fall;
         pos_seen <= 1'b0;
      end
      else if (pos_fall)
         pos_seen <= 1'b1;
   end

   always_comb
   begin
      if (hd)
         cls = ((period >= vste_pkg::HD720_MIN_PERIOD) &&
                (period <= vste_pkg::HD720_MAX_PERIOD)) ?
               vste_pkg::VSTE_HD720 : vste_pkg::VSTE_HD1080;
      else if (period > vste_pkg::ED_MAX_PERIOD)
         cls = vste_pkg::VSTE_SD;
      else
         cls = vste_pkg::VSTE_ED;
   end

   // Tri-level trailing edge in HD, sync rise otherwise
   assign bp_trig = !nosig && (hd ? pos_fall : sync_rise);

   // Event data changes only with its toggle, so it is stable on capture
   always_ff @(posedge I_VID_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         evt <= '0;
         vx <= '{hs_tgl: 1'b0, bp_tgl: 1'b0, csync: 1'b1, vs_n: 1'b1,
                 parity: 1'b1, fmt: 1'b0, nosig: 1'b1};
      end
      else
      begin
         if (hs_accept || bp_trig)
            evt <= '{cls: cls, short_w: vert};
         if (hs_accept)
            vx.hs_tgl <= ~vx.hs_tgl;
         if (bp_trig)
            vx.bp_tgl <= ~vx.bp_tgl;
         vx.csync <= s_sync[1];
         vx.vs_n <= ~(vs_active & ~nosig);
         vx.parity <= O_FIELD_PARITY_OUT;
         vx.fmt <= fmt_bit;
         vx.nosig <= nosig;
      end
   end

   // ==========================================================
   // Reference domain: crossing and output pulse timing
   vste_pkg::vste_xing_t rx_meta;
   vste_pkg::vste_xing_t rx;
   logic hs_tgl_d;
   logic bp_tgl_d;
   logic hs_fire;
   logic bp_fire;
   logic [PW-1:0] hs_w;
   logic [PW-1:0] bp_w;

   always_ff @(posedge I_REF_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         rx_meta <= '{hs_tgl: 1'b0, bp_tgl: 1'b0, csync: 1'b1, vs_n: 1'b1,
                      parity: 1'b1, fmt: 1'b0, nosig: 1'b1};
         rx <= '{hs_tgl: 1'b0, bp_tgl: 1'b0, csync: 1'b1, vs_n: 1'b1,
                 parity: 1'b1, fmt: 1'b0, nosig: 1'b1};
      end
      else
      begin
         rx_meta <= vx;
         rx <= rx_meta;
      end
   end

   always_ff @(posedge I_REF_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         hs_tgl_d <= 1'b0;
         bp_tgl_d <= 1'b0;
         hs_fire <= 1'b0;
         bp_fire <= 1'b0;
         hs_w <= vste_pkg::HS_SD_CYC;
         bp_w <= vste_pkg::BP_SD_CYC;
      end
      else
      begin
         hs_tgl_d <= rx.hs_tgl;
         bp_tgl_d <= rx.bp_tgl;
         hs_fire <= (rx.hs_tgl != hs_tgl_d) && !rx.nosig;
         bp_fire <= (rx.bp_tgl != bp_tgl_d) && !rx.nosig;
         if (rx.hs_tgl != hs_tgl_d)
            case (evt.cls)
               vste_pkg::VSTE_HD720: hs_w <= vste_pkg::HS_720_CYC;
               vste_pkg::VSTE_HD1080: hs_w <= vste_pkg::HS_1080_CYC;
               default: hs_w <= vste_pkg::HS_SD_CYC;
            endcase
         if (rx.bp_tgl != bp_tgl_d)
         begin
            if (evt.cls == vste_pkg::VSTE_HD720 ||
                evt.cls == vste_pkg::VSTE_HD1080)
               bp_w <= vste_pkg::BP_HD_CYC;
            else if (evt.cls == vste_pkg::VSTE_ED || evt.short_w)
               bp_w <= vste_pkg::BP_SHORT_CYC;
            else
               bp_w <= vste_pkg::BP_SD_CYC;
         end
      end
   end

   // Only the falling edge is timed to the input; the rise is rebuilt
   vste_pulse #(.W(PW)) u_hs_pulse
   (
      .i_clk(I_REF_CLK),
      .i_rst_n(I_RST_N),
      .i_fire(hs_fire),
      .i_width(hs_w),
      .o_low_n(O_LINE_SYNC_OUT)
   );

   vste_pulse #(.W(PW)) u_bp_pulse
   (
      .i_clk(I_REF_CLK),
      .i_rst_n(I_RST_N),
      .i_fire(bp_fire),
      .i_width(bp_w),
      .o_low_n(O_BACK_PORCH_GATE_OUT)
   );

   always_ff @(posedge I_REF_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         O_COMPOSITE_SYNC_OUT <= 1'b1;
         O_FIELD_SYNC_OUT <= 1'b1;
         O_LINE_COUNT_SERIAL_OUT <= 1'b0;
      end
      else
      begin
         O_COMPOSITE_SYNC_OUT <= rx.csync;
         O_FIELD_SYNC_OUT <= rx.vs_n;
         O_LINE_COUNT_SERIAL_OUT <= rx.fmt;
      end
   end

   // ==========================================================
   // Checks
   logic [PW-1:0] hs_len;
   logic [PW-1:0] bp_len;

   always_ff @(posedge I_REF_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         hs_len <= '0;
         bp_len <= '0;
      end
      else
      begin
         hs_len <= O_LINE_SYNC_OUT ? '0 : PW'(hs_len + 1'b1);
         bp_len <= O_BACK_PORCH_GATE_OUT ? '0 : PW'(bp_len + 1'b1);
      end
   end

   sequence s_field_start;
      vs_start;
   endsequence

   sequence s_word_cleared;
      ##1 (line_cnt == '0);
   endsequence

   a_hs_width: assert property (
      @(posedge I_REF_CLK) disable iff (!I_RST_N)
      $rose(O_LINE_SYNC_OUT) |-> hs_len == hs_w)
      else $error("line sync low width wrong");

   a_bp_width: assert property (
      @(posedge I_REF_CLK) disable iff (!I_RST_N)
      $rose(O_BACK_PORCH_GATE_OUT) |-> bp_len == bp_w)
      else $error("back porch gate width wrong");

   a_bp_ed_short: assert property (
      @(posedge I_REF_CLK) disable iff (!I_RST_N)
      (rx.bp_tgl != bp_tgl_d) && evt.cls == vste_pkg::VSTE_ED
      |=> bp_w == vste_pkg::BP_SHORT_CYC)
      else $error("enhanced definition gate not short");

   a_vs_three_lines: assert property (
      @(posedge I_VID_CLK) disable iff (!I_RST_N)
      $fell(vs_active) && !$past(nosig) |->
      vcount == vste_pkg::VS_LINES && $past(hs_accept))
      else $error("field sync not three lines long");

   a_parity_edge: assert property (
      @(posedge I_VID_CLK) disable iff (!I_RST_N)
      $changed(O_FIELD_PARITY_OUT) |-> $past(vs_start))
      else $error("parity moved away from field sync");

   a_count_capture: assert property (
      @(posedge I_VID_CLK) disable iff (!I_RST_N)
      s_field_start |-> s_word_cleared ##0 fmt_word == $past(line_cnt))
      else $error("line count not captured at field start");

   a_count_skip_vs: assert property (
      @(posedge I_VID_CLK) disable iff (!I_RST_N)
      hs_accept && vs_active && !vs_start |=> line_cnt == $past(line_cnt))
      else $error("line counted during field sync");

   a_fmt_third_hs: assert property (
      @(posedge I_VID_CLK) disable iff (!I_RST_N)
      ser_state == vste_pkg::VSTE_SER_WAIT && hs_accept &&
      ser_cnt == 2'h2 && !vs_start
      |=> ser_state == vste_pkg::VSTE_SER_SHIFT &&
      fmt_bit == $past(fmt_word[vste_pkg::FMT_BITS-1]))
      else $error("format word did not start on third line sync");

   a_nosig_vs_high: assert property (
      @(posedge I_VID_CLK) disable iff (!I_RST_N)
      nosig [*2] |-> vx.vs_n)
      else $error("field sync low without input");
endmodule

/* File: logic/vste_pkg.sv */
// Purpose: Shared constants and types for the video sync timing extractor
// Assumes: Reference clock 50 MHz, video sample clock 8 MHz
// Notes: Video-domain counts are in sample-clock cycles or lines
package vste_pkg;

   // ==========================================================
   // Clock rates
   localparam int REF_MHZ = 50;

   // ==========================================================
   // Output pulse widths, in ns, and their reference-clock counts
   localparam int PW_W = 8;
   localparam int HS_720_NS = 525;
   localparam int HS_1080_NS = 475;
   localparam int HS_SD_NS = 4700;
   localparam int BP_HD_NS = 350;
   localparam int BP_SD_NS = 2500;
   localparam int BP_SHORT_NS = 1000;
   localparam logic [PW_W-1:0] HS_720_CYC =
      PW_W'((HS_720_NS * REF_MHZ + 999) / 1000);
   localparam logic [PW_W-1:0] HS_1080_CYC =
      PW_W'((HS_1080_NS * REF_MHZ + 999) / 1000);
   localparam logic [PW_W-1:0] HS_SD_CYC =
      PW_W'((HS_SD_NS * REF_MHZ + 999) / 1000);
   localparam logic [PW_W-1:0] BP_HD_CYC =
      PW_W'((BP_HD_NS * REF_MHZ + 999) / 1000);
   localparam logic [PW_W-1:0] BP_SD_CYC =
      PW_W'((BP_SD_NS * REF_MHZ + 999) / 1000);
   localparam logic [PW_W-1:0] BP_SHORT_CYC =
      PW_W'((BP_SHORT_NS * REF_MHZ + 999) / 1000);

   // ==========================================================
   // Video-domain counts (sample-clock cycles or lines)
   localparam int TMR_W = 12;
   localparam logic [TMR_W-1:0] NOSIG_VCYC = 12'h800;
   localparam logic [TMR_W-1:0] ED_MAX_PERIOD = 12'h190;
   localparam logic [TMR_W-1:0] HD720_MIN_PERIOD = 12'h096;
   localparam logic [TMR_W-1:0] HD720_MAX_PERIOD = 12'h0C8;
   localparam logic [3:0] VS_LINES = 4'h3;
   localparam logic [3:0] VERT_LINES = 4'h9;
   localparam logic [4:0] RELOCK_MISSES = 5'h10;
   localparam logic [1:0] FMT_FIRST_HS = 2'h3;
   localparam int FMT_BITS = 11;
   localparam logic [3:0] FMT_BITS_CNT = 4'hB;

   // ==========================================================
   // Types
   typedef enum logic [1:0]
   {
      VSTE_SD = 2'h0,
      VSTE_ED = 2'h1,
      VSTE_HD720 = 2'h2,
      VSTE_HD1080 = 2'h3
   } vste_class_t;

   typedef enum logic [2:0]
   {
      VSTE_SER_IDLE = 3'h1,
      VSTE_SER_WAIT = 3'h2,
      VSTE_SER_SHIFT = 3'h4
   } vste_ser_t;

   typedef struct packed
   {
      vste_class_t cls;
      logic short_w;
   } vste_evt_t;

   typedef struct packed
   {
      logic hs_tgl;
      logic bp_tgl;
      logic csync;
      logic vs_n;
      logic parity;
      logic fmt;
      logic nosig;
   } vste_xing_t;

endpackage

/* File: dv/vste_rx_model.sv */
// Purpose: Receiving logic that decodes the serial format word
// Assumes: Line and field sync falling edges are the only timing references
// Notes: Samples each bit well after its line sync edge, away from changes
module vste_rx_model
(
   input wire logic i_line_n,
   input wire logic i_field_n,
   input wire logic i_fmt,
   output logic [10:0] o_word,
   output logic [10:0] o_prev,
   output int o_words
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // Decoder
   logic [10:0] sh;
   int n;
   initial
   begin
      sh = 11'h000;
      o_word = 11'h000;
      o_prev = 11'h000;
      o_words = 0;
      n = 99;
   end
   always @(negedge i_field_n) n = 0;
   // Trailing edges are rebuilt on every line, so never used
   always @(negedge i_line_n)
   begin
      n = n + 1;
      if (n >= 3 && n <= 13)
      begin
         #3000;
         sh = {sh[9:0], i_fmt};
         if (n == 13)
         begin
            o_prev = o_word;
            o_word = sh;
            o_words = o_words + 1;
         end
      end
   end
endmodule

/* File: dv/tb.sv */
// Purpose: Self-checking bench for the video sync timing extractor
// Assumes: Video sample clock 125 ns, unrelated in phase to 20 ns
// Notes: Short synthetic lines keep the run brief; class set by period and tri-level pulse
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // Clocks, design and receiver
   logic clk, vclk, rst_n, sync_n, tri_pos;
   logic csync, hs_n, vs_n, bp_n, par, fmt;
   logic [10:0] word, prev;
   int words, mismatches, n_checks;
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial
   begin
      vclk = 1'b0;
      #7;
      forever #62.5 vclk = ~vclk;
   end
   vste_top i_dut
   (
      .I_REF_CLK(clk), .I_RST_N(rst_n), .I_VID_CLK(vclk),
      .I_SYNC_BELOW_N(sync_n), .I_SYNC_TRI_POS(tri_pos),
      .O_COMPOSITE_SYNC_OUT(csync), .O_LINE_SYNC_OUT(hs_n),
      .O_FIELD_SYNC_OUT(vs_n), .O_BACK_PORCH_GATE_OUT(bp_n),
      .O_FIELD_PARITY_OUT(par), .O_LINE_COUNT_SERIAL_OUT(fmt)
   );
   vste_rx_model i_rx
   (
      .i_line_n(hs_n), .i_field_n(vs_n), .i_fmt(fmt),
      .o_word(word), .o_prev(prev), .o_words(words)
   );
   // ==========================================================
   // Compare and report
   task automatic check_num(input int got, input int lo, input int hi,
      input string what);
      n_checks++;
      if (got < lo || got > hi)
      begin
         mismatches++;
         $display("MISMATCH %0t %s got %0d", $time, what, got);
      end
   endtask
   task automatic check_bit(input logic got, input logic exp,
      input string what);
      n_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("MISMATCH %0t %s got %b", $time, what, got);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // ==========================================================
   // Drivers and probes
   function automatic logic pick(input int sel);
      case (sel)
         0: return hs_n;
         1: return bp_n;
         2: return csync;
         default: return vs_n;
      endcase
   endfunction
   // Counts reference edges to the fall, then edges spent low
   task automatic low_width(input int sel, output int lat, output int w);
      lat = 0;
      w = 0;
      while (pick(sel) !== 1'b0)
      begin
         // Look after the edge has settled, not in its own time step
         @(posedge clk);
         #1;
         lat++;
         if (lat > 30000)
         begin
            mismatches++;
            $display("MISMATCH %0t no pulse on output %0d", $time, sel);
            tally_and_finish();
         end
      end
      while (pick(sel) === 1'b0 && w < 30000)
      begin
         @(posedge clk);
         #1;
         w++;
      end
   endtask
   task automatic vline(input int per, input int low, input int pos);
      sync_n <= 1'b0;
      repeat (low) @(posedge vclk);
      sync_n <= 1'b1;
      if (pos > 0)
      begin
         tri_pos <= 1'b1;
         repeat (pos) @(posedge vclk);
         tri_pos <= 1'b0;
      end
      repeat (per - low - pos) @(posedge vclk);
   endtask
   // ==========================================================
   // Scenarios
   task automatic sc_idle();
      repeat (400) @(posedge clk);
      check_bit(hs_n, 1'b1, "line sync idle");
      check_bit(vs_n, 1'b1, "field sync idle");
      check_bit(bp_n, 1'b1, "back porch idle");
   endtask
   // Measures the line after nl lines; a long first sync after a shorter
   // period looks broad and opens a vertical zone of nine lines
   task automatic sc_line(input int per, input int low, input int pos,
      input int hs, input int bp, input int nl);
      int hl, hw, bl, bw, cl, cw, at;
      at = (low + pos) * 25 / 4;
      fork
         repeat (nl + 1) vline(per, low, pos);
         begin
            repeat (nl * per) @(posedge vclk);
            fork
               low_width(0, hl, hw);
               low_width(1, bl, bw);
               low_width(2, cl, cw);
            join
         end
      join
      check_num(hw, hs, hs, "line sync width");
      check_num(hl, 8, 40, "line sync delay");
      check_num(bw, bp, bp, "back porch width");
      check_num(bl, at + 8, at + 40, "back porch delay");
      check_num(cw, low * 25 / 4 - 8, low * 25 / 4 + 8, "csync");
      check_num(cl, 8, 40, "composite delay");
   endtask
   // Four progressive fields of 20 lines, three broad pulses each
   task automatic sc_fields();
      int lat, w;
      fork
         repeat (4)
         begin
            repeat (3) vline(100, 88, 0);
            repeat (17) vline(100, 8, 0);
         end
         repeat (3)
         begin
            low_width(3, lat, w);
            check_bit(par, 1'b1, "parity progressive");
            check_num(w, 1150, 1975, "field sync width");
         end
      join
      check_num(words, 3, 4, "format words");
      check_num(int'(word), 15, 19, "line count");
      check_num(int'(prev), int'(word), int'(word), "repeat");
   endtask
   // ==========================================================
   // Main sequence
   initial
   begin
      mismatches = 0;
      n_checks = 0;
      rst_n = 1'b0;
      sync_n = 1'b1;
      tri_pos = 1'b0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      sc_idle();
      @(posedge vclk);
      sc_line(100, 8, 0, 235, 50, 5);
      sc_fields();
      sc_line(100, 4, 4, 24, 18, 5);
      sc_line(170, 4, 4, 27, 18, 5);
      sc_line(410, 30, 0, 235, 125, 11);
      tally_and_finish();
   end
endmodule
